// [hw/spf_top.sv]
// Function select for the shared PWM, interrupt, GPIO and clock-out pins.
// Assumes a single 40 MHz clock and a register master on the same clock.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Behaviour
// - Reset: shared pin is interrupt one plus GPIO
// - Interrupt one follows pin only when enabled
// - GPIO input free; output needs direction write
// - Select bit 8 drives timer two PWM
// - Interrupt one ignores select bit 8
// - Second pin feeds every enabled function at once
// - Interrupt two needs its enable bit
// - ADC trigger needs its enable bit
// - Capture one needs capture select bits
// - Select bit 7 outputs CPU clock
// - Clock out: peripheral inputs see constant one
// - PWM pins: compare output or GPIO
// - Test-data pin: GPIO output only; its input feeds test data only
module spf_top (
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Peripheral side
  input wire logic [2:0] pwm_channel_out,
  input wire logic timer_two_pwm_out,
  input wire logic cpu_clock_source,
  output logic ext_interrupt_one,
  output logic ext_interrupt_two,
  output logic adc_conversion_trigger_in,
  output logic capture_input_one,
  output logic jtag_tdi,
  // Shared PWM pins, channels four to six
  input wire logic [2:0] pwm_pin_in,
  output logic [2:0] pwm_pin_out,
  output logic [2:0] pwm_pin_oe,
  // Timer PWM / interrupt one / port B bit zero pin
  input wire logic pin_a_in,
  output logic pin_a_out,
  output logic pin_a_oe,
  // Interrupt two / ADC trigger / capture / port A bit seven / clock pin
  input wire logic pin_b_in,
  output logic pin_b_out,
  output logic pin_b_oe,
  // Test-data-in / port B bit five output pin
  input wire logic tdi_pin_in,
  output logic tdi_pin_out,
  output logic tdi_pin_oe,
  input wire logic jtag_trst
);
  logic [15:0] pin_function_control_q;
  logic [15:0] pin_function_control_d;
  logic [15:0] port_a_data_direction_q;
  logic [15:0] port_a_data_direction_d;
  logic [15:0] port_b_data_direction_q;
  logic [15:0] port_b_data_direction_d;
  logic [15:0] ext_interrupt_one_control_q;
  logic [15:0] ext_interrupt_one_control_d;
  logic [15:0] ext_interrupt_two_control_q;
  logic [15:0] ext_interrupt_two_control_d;
  logic [15:0] adc_control_second_q;
  logic [15:0] adc_control_second_d;
  logic [15:0] capture_control_q;
  logic [15:0] capture_control_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // Synchronised pin levels
  logic [5:0] pins_raw;
  logic [5:0] pins_sync;
  logic pin_a_lvl;
  logic pin_b_lvl;
  logic [2:0] pwm_lvl;
  logic trst_lvl;

  // Flops reset to one, the pull-up level, so no false low follows reset
  assign pins_raw = {jtag_trst, pwm_pin_in, pin_b_in, pin_a_in};

  spf_sync #(
    .WIDTH(spf_pkg::SYNC_PINS)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign pin_a_lvl = pins_sync[spf_pkg::ST_PIN_A_BIT];
  assign pin_b_lvl = pins_sync[spf_pkg::ST_PIN_B_BIT];
  assign pwm_lvl = pins_sync[spf_pkg::ST_PWM_LSB +: spf_pkg::PWM_PINS];
  assign trst_lvl = pins_sync[spf_pkg::ST_TRST_BIT];

  // The test-data input is deliberately not synchronised into any port bit;
  // it is only passed to the scan logic while the test reset is high.
  logic tdi_sync;
  spf_sync #(
    .WIDTH(1)
  ) u_tdi_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(tdi_pin_in),
    .sync_out(tdi_sync)
  );

  // Address decode
  logic sel_pfc;
  logic sel_pa;
  logic sel_pb;
  logic sel_x1;
  logic sel_x2;
  logic sel_adc;
  logic sel_cap;
  logic sel_st;
  assign sel_pfc = (reg_addr == spf_pkg::OFS_PIN_FUNCTION_CONTROL);
  assign sel_pa = (reg_addr == spf_pkg::OFS_PORT_A_DATA_DIRECTION);
  assign sel_pb = (reg_addr == spf_pkg::OFS_PORT_B_DATA_DIRECTION);
  assign sel_x1 = (reg_addr == spf_pkg::OFS_EXT_INTERRUPT_ONE_CONTROL);
  assign sel_x2 = (reg_addr == spf_pkg::OFS_EXT_INTERRUPT_TWO_CONTROL);
  assign sel_adc = (reg_addr == spf_pkg::OFS_ADC_CONTROL_SECOND);
  assign sel_cap = (reg_addr == spf_pkg::OFS_CAPTURE_CONTROL);
  assign sel_st = (reg_addr == spf_pkg::OFS_PIN_STATUS);

  logic wr_pfc;
  logic wr_pa;
  logic wr_pb;
  logic wr_x1;
  logic wr_x2;
  logic wr_adc;
  logic wr_cap;
  assign wr_pfc = reg_wr && sel_pfc;
  assign wr_pa = reg_wr && sel_pa;
  assign wr_pb = reg_wr && sel_pb;
  assign wr_x1 = reg_wr && sel_x1;
  assign wr_x2 = reg_wr && sel_x2;
  assign wr_adc = reg_wr && sel_adc;
  assign wr_cap = reg_wr && sel_cap;

  wire [15:0] port_mask_a = {spf_pkg::PORT_A_MASK, spf_pkg::PORT_A_MASK};
  wire [15:0] port_mask_b = {spf_pkg::PORT_B_MASK, spf_pkg::PORT_B_MASK};

  // Next values of the writable registers
  // Masks keep unimplemented bits reading zero
  // select bits stored
  assign pin_function_control_d = wr_pfc ?
    (reg_wdata & spf_pkg::PFC_MASK) : pin_function_control_q;
  assign port_a_data_direction_d = wr_pa ?
    (reg_wdata & port_mask_a) : port_a_data_direction_q;
  assign port_b_data_direction_d = wr_pb ?
    (reg_wdata & port_mask_b) : port_b_data_direction_q;
  assign ext_interrupt_one_control_d = wr_x1 ?
    (reg_wdata & spf_pkg::ENABLE_MASK) : ext_interrupt_one_control_q;
  assign ext_interrupt_two_control_d = wr_x2 ?
    (reg_wdata & spf_pkg::ENABLE_MASK) : ext_interrupt_two_control_q;
  assign adc_control_second_d = wr_adc ?
    (reg_wdata & spf_pkg::ENABLE_MASK) : adc_control_second_q;
  assign capture_control_d = wr_cap ?
    (reg_wdata & spf_pkg::CAP_MASK) : capture_control_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_function_control_q <= spf_pkg::RST_VALUE;
    end else begin
      pin_function_control_q <= pin_function_control_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_a_data_direction_q <= spf_pkg::RST_VALUE;
    end else begin
      port_a_data_direction_q <= port_a_data_direction_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_b_data_direction_q <= spf_pkg::RST_VALUE;
    end else begin
      port_b_data_direction_q <= port_b_data_direction_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_interrupt_one_control_q <= spf_pkg::RST_VALUE;
    end else begin
      ext_interrupt_one_control_q <= ext_interrupt_one_control_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_interrupt_two_control_q <= spf_pkg::RST_VALUE;
    end else begin
      ext_interrupt_two_control_q <= ext_interrupt_two_control_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adc_control_second_q <= spf_pkg::RST_VALUE;
    end else begin
      adc_control_second_q <= adc_control_second_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      capture_control_q <= spf_pkg::RST_VALUE;
    end else begin
      capture_control_q <= capture_control_d;
    end
  end

  // Field views
  logic [2:0] pwm_sel;
  logic cpu_clock_output_sel;
  logic timer_two_pwm_out_sel;
  logic [7:0] pa_data;
  logic [7:0] pa_dir;
  logic [7:0] pb_data;
  logic [7:0] pb_dir;
  logic x1_en;
  logic x2_en;
  logic adc_en;
  logic [1:0] cap_sel;
  assign pwm_sel = pin_function_control_q[spf_pkg::PFC_PWM_SEL_LSB +: 3];
  assign cpu_clock_output_sel = pin_function_control_q[spf_pkg::PFC_CPU_CLOCK_OUTPUT_BIT];
  assign timer_two_pwm_out_sel = pin_function_control_q[spf_pkg::PFC_TIMER_TWO_PWM_OUT_BIT];
  assign pa_data = port_a_data_direction_q[7:0];
  assign pa_dir = port_a_data_direction_q[spf_pkg::DIR_LSB +: 8];
  assign pb_data = port_b_data_direction_q[7:0];
  assign pb_dir = port_b_data_direction_q[spf_pkg::DIR_LSB +: 8];
  assign x1_en = ext_interrupt_one_control_q[spf_pkg::XINT_EN_BIT];
  assign x2_en = ext_interrupt_two_control_q[spf_pkg::XINT_EN_BIT];
  assign adc_en = adc_control_second_q[spf_pkg::ADC_EXT_SOC_BIT];
  assign cap_sel = capture_control_q[spf_pkg::CAP_SEL_LSB +: spf_pkg::CAP_SEL_W];

  // PWM channel pins four to six
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_pwm
      assign pwm_pin_out[gp] = pwm_sel[gp] ? pwm_channel_out[gp] :
        pa_data[spf_pkg::PA_PWM_LSB + gp];
      assign pwm_pin_oe[gp] = pwm_sel[gp] | pa_dir[spf_pkg::PA_PWM_LSB + gp];
    end
  endgenerate

  // First shared pin
  // GPIO role after reset
  assign pin_a_out = timer_two_pwm_out_sel ? timer_two_pwm_out : pb_data[spf_pkg::PB_SHARED_BIT];
  assign pin_a_oe = timer_two_pwm_out_sel | pb_dir[spf_pkg::PB_SHARED_BIT];
  // Interrupt one keeps sampling the pin, even under PWM drive
  // enable gates interrupt
  assign ext_interrupt_one = x1_en ? pin_a_lvl : 1'b1;

  // Second shared pin
  // Clock out overrides port A bit seven drive
  // clock on pin
  assign pin_b_out = cpu_clock_output_sel ? cpu_clock_source : pa_data[spf_pkg::PA_SHARED_BIT];
  assign pin_b_oe = cpu_clock_output_sel | pa_dir[spf_pkg::PA_SHARED_BIT];

  logic pin_b_func;
  assign pin_b_func = cpu_clock_output_sel ? 1'b1 : pin_b_lvl;

  // Users of the second pin: interrupt two, ADC trigger, capture one
  logic [2:0] pin_b_user_en;
  logic [2:0] pin_b_user_in;
  assign pin_b_user_en = {x2_en, adc_en, (cap_sel != 2'h0)};
  genvar gu;
  generate
    for (gu = 0; gu < 3; gu++) begin : g_pin_b_user
      assign pin_b_user_in[gu] = pin_b_user_en[gu] ? pin_b_func : 1'b1;
    end
  endgenerate
  assign ext_interrupt_two = pin_b_user_in[2];
  assign adc_conversion_trigger_in = pin_b_user_in[1];
  assign capture_input_one = pin_b_user_in[0];

  // Test-data pin, output role while the test reset is low
  logic tdi_output_role;
  assign tdi_output_role = !trst_lvl;
  assign tdi_pin_out = pb_data[spf_pkg::PB_OUT_ONLY_BIT];
  assign tdi_pin_oe = tdi_output_role && pb_dir[spf_pkg::PB_OUT_ONLY_BIT];
  assign jtag_tdi = tdi_output_role ? 1'b1 : tdi_sync;

  // Port input levels, data bits read pins when used as inputs
  logic [7:0] pa_pins;
  logic [7:0] pb_pins;
  logic [7:0] pa_read;
  logic [7:0] pb_read;
  logic [15:0] pa_word;
  logic [15:0] pb_word;
  logic [15:0] status_word;
  assign pa_pins = {pin_b_lvl, pwm_lvl, 4'h0};
  assign pb_pins = {7'h00, pin_a_lvl};
  assign pa_read = ((pa_dir & pa_data) | (~pa_dir & pa_pins)) &
    spf_pkg::PORT_A_MASK;
  assign pb_read = ((pb_dir & pb_data) | (~pb_dir & pb_pins)) &
    spf_pkg::PORT_B_MASK;
  assign pa_word = {pa_dir, pa_read};
  assign pb_word = {pb_dir, pb_read};

  assign status_word = {10'h000, trst_lvl, pwm_lvl, pin_b_lvl, pin_a_lvl};

  // Read mux, unmapped addresses read zero
  logic [15:0] rd_word;
  // Read data stands one cycle, zero otherwise
  assign rdata_d = reg_rd ? rd_word : 16'h0000;
  assign rd_word = sel_pfc ? pin_function_control_q :
    sel_pa ? pa_word :
    sel_pb ? pb_word :
    sel_x1 ? ext_interrupt_one_control_q :
    sel_x2 ? ext_interrupt_two_control_q :
    sel_adc ? adc_control_second_q :
    sel_cap ? capture_control_q :
    sel_st ? status_word :
    16'h0000;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= spf_pkg::RST_VALUE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// [hw/spf_pkg.sv]
// Constants for the shared pin function select block.
// Assumes a 16-bit register port with a 4-bit word address.
package spf_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // Register offsets (word addresses)
  localparam logic [3:0] OFS_PIN_FUNCTION_CONTROL = 4'h0;
  localparam logic [3:0] OFS_PORT_A_DATA_DIRECTION = 4'h1;
  localparam logic [3:0] OFS_PORT_B_DATA_DIRECTION = 4'h2;
  localparam logic [3:0] OFS_EXT_INTERRUPT_ONE_CONTROL = 4'h3;
  localparam logic [3:0] OFS_EXT_INTERRUPT_TWO_CONTROL = 4'h4;
  localparam logic [3:0] OFS_ADC_CONTROL_SECOND = 4'h5;
  localparam logic [3:0] OFS_CAPTURE_CONTROL = 4'h6;
  localparam logic [3:0] OFS_PIN_STATUS = 4'h7;

  // Pin function control fields
  localparam int unsigned PFC_PWM_SEL_LSB = 4;
  localparam int unsigned PFC_CPU_CLOCK_OUTPUT_BIT = 7;
  localparam int unsigned PFC_TIMER_TWO_PWM_OUT_BIT = 8;
  localparam logic [15:0] PFC_MASK = 16'h01F0;

  // Data/direction layout: direction in the high byte, data in the low byte
  localparam int unsigned DIR_LSB = 8;
  localparam logic [7:0] PORT_A_MASK = 8'hF0;
  localparam logic [7:0] PORT_B_MASK = 8'h21;
  localparam int unsigned PA_PWM_LSB = 4;
  localparam int unsigned PA_SHARED_BIT = 7;
  localparam int unsigned PB_SHARED_BIT = 0;
  localparam int unsigned PB_OUT_ONLY_BIT = 5;

  // Peripheral enable fields
  localparam int unsigned XINT_EN_BIT = 0;
  localparam int unsigned ADC_EXT_SOC_BIT = 0;
  localparam int unsigned CAP_SEL_LSB = 0;
  localparam int unsigned CAP_SEL_W = 2;
  localparam logic [15:0] ENABLE_MASK = 16'h0001;
  localparam logic [15:0] CAP_MASK = 16'h0003;

  // Values after reset
  localparam logic [15:0] RST_VALUE = 16'h0000;

  // Pin status bits
  localparam int unsigned ST_PIN_A_BIT = 0;
  localparam int unsigned ST_PIN_B_BIT = 1;
  localparam int unsigned ST_PWM_LSB = 2;
  localparam int unsigned ST_TRST_BIT = 5;

  localparam int unsigned PWM_PINS = 3;
  localparam int unsigned SYNC_PINS = 6;
endpackage

// [hw/spf_sync.sv]
// Two-stage synchroniser, one stage pair per bit.
// Assumes inputs come from pins outside the clock domain.
`timescale 1ns/10ps
module spf_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic first_q;
      logic second_q;
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          first_q <= 1'b1;
          second_q <= 1'b1;
        end else begin
          first_q <= async_in[gi];
          second_q <= first_q;
        end
      end
      assign sync_out[gi] = second_q;
    end
  endgenerate
endmodule

// [dv/spf_top_monitor.sv]
// Checker for the shared pin select ports.
// Assumes it is bound into spf_top and sees only its ports.
`timescale 1ns/10ps
module spf_top_monitor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] pwm_channel_out,
  input wire logic timer_two_pwm_out,
  input wire logic cpu_clock_source,
  input wire logic ext_interrupt_one,
  input wire logic ext_interrupt_two,
  input wire logic adc_conversion_trigger_in,
  input wire logic capture_input_one,
  input wire logic jtag_tdi,
  input wire logic [2:0] pwm_pin_out,
  input wire logic [2:0] pwm_pin_oe,
  input wire logic pin_a_in,
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  input wire logic tdi_pin_oe
);
  // Shadow of select and enable bits
  logic [15:0] pfc_q;
  logic [3:0] en_q;
  logic [2:0] sel;
  logic [2:0] off;
  assign sel = pfc_q[6:4];
  assign off = ~{en_q[1], en_q[2], en_q[3]} | {3{pfc_q[7]}};
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pfc_q <= 16'h0000;
      en_q <= 4'h0;
    end else if (reg_wr && reg_addr == 4'h0) begin
      pfc_q <= reg_wdata & spf_pkg::PFC_MASK;
    end else if (reg_wr && reg_addr >= 4'h3 && reg_addr <= 4'h6) begin
      en_q[reg_addr[1:0] + 2'h1] <= (reg_addr == 4'h6) ? |reg_wdata[1:0] : reg_wdata[0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_read_ctl; reg_rd && reg_addr == 4'h0; endsequence
  sequence s_sync_live; $past(rst_n) && $past(rst_n, 2); endsequence
  a_int_one_follow: assert property (en_q[0] ##0 s_sync_live |-> ext_interrupt_one == $past(pin_a_in, 2))
    else $error("interrupt one does not follow its pin");
  a_disabled_ones: assert property (|off |-> (off & ~{ext_interrupt_two, adc_conversion_trigger_in, capture_input_one}) == 3'b000)
    else $error("disabled peripheral input not one");
  a_clk_out_pin: assert property (pfc_q[7] |-> pin_b_oe && pin_b_out == cpu_clock_source)
    else $error("clock not on second pin");
  a_timer_two_pwm_out_route: assert property (pfc_q[8] |-> pin_a_oe && pin_a_out == timer_two_pwm_out)
    else $error("timer two pwm not on pin");
  a_pwm_select: assert property (|sel |-> (pwm_pin_oe & sel) == sel && ((pwm_pin_out ^ pwm_channel_out) & sel) == 3'b000)
    else $error("pwm pin not driven by channel");
  a_read_ctl: assert property (s_read_ctl |=> reg_rdata == $past(pfc_q))
    else $error("select register read wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !pin_a_oe && !pin_b_oe && pwm_pin_oe == 3'b000 && ext_interrupt_one)
    else $error("pins not idle after reset");
  a_tdi_out_only: assert property (tdi_pin_oe |-> jtag_tdi)
    else $error("test data input seen while pin drives");
endmodule
bind spf_top spf_top_monitor mon (.*);

// [dv/spf_board.sv]
// Board side of the shared pins: pull-ups and optional drivers.
// Assumes the bench sets the driver enables and levels.
`timescale 1ns/10ps
module spf_board #(
  parameter int N = 6
) (
  input wire logic [N-1:0] pin_oe,
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] pin_lvl
);
  // Device drive wins, then board driver, then pull-up
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

// [dv/shared_pin_function_select_tb.sv]
// Self-checking bench for the shared pin function select block.
// Assumes spf_board models the pins and the checker is bound in.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module shared_pin_function_select_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] pwm_channel_out = 3'h0;
  logic timer_two_pwm_out = 1'b0;
  logic cpu_clock_source = 1'b0;
  logic jtag_trst = 1'b0;
  logic [5:0] ext_en = 6'h00;
  logic [5:0] ext_val = 6'h00;
  wire [5:0] pin_oe;
  wire [5:0] pin_out;
  logic [5:0] pin_lvl;
  logic [15:0] reg_rdata;
  logic [15:0] rd_q;
  logic [2:0] v;
  logic ext_interrupt_one;
  logic ext_interrupt_two;
  logic adc_conversion_trigger_in;
  logic capture_input_one;
  logic jtag_tdi;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h7c7a6e61;
  wire [2:0] per = {ext_interrupt_two, adc_conversion_trigger_in, capture_input_one};
  always #12.5 clock = ~clock;
  spf_top uut (.*, .pwm_pin_in(pin_lvl[4:2]), .pwm_pin_out(pin_out[4:2]),
    .pwm_pin_oe(pin_oe[4:2]), .pin_a_in(pin_lvl[0]), .pin_a_out(pin_out[0]),
    .pin_a_oe(pin_oe[0]), .pin_b_in(pin_lvl[1]), .pin_b_out(pin_out[1]),
    .pin_b_oe(pin_oe[1]), .tdi_pin_in(pin_lvl[5]), .tdi_pin_out(pin_out[5]),
    .tdi_pin_oe(pin_oe[5]));
  spf_board #(.N(6)) board (.pin_oe(pin_oe), .pin_out(pin_out), .ext_en(ext_en),
    .ext_val(ext_val), .pin_lvl(pin_lvl));
  function automatic logic [2:0] exp_per(int k, logic p);
    exp_per = 3'h7;
    exp_per[2-k] = p;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_q = reg_rdata;
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    $display("Error watchdog expected done seen hang");
    final_report();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    `CHK("pin oe", 6'h00, pin_oe)
    `CHK("int one", 1'b1, ext_interrupt_one)
    rd(4'h0);
    `CHK("select reg", 16'h0000, rd_q)
    rd(4'h9);
    `CHK("unmapped", 16'h0000, rd_q)
    $display("test reset done");
    ext_en <= 6'h02;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      ext_val <= 6'($random(seed));
      settle();
      rd(4'h1);
      `CHK("port a bit7", ext_val[1], rd_q[7])
      `CHK("pin b oe", 1'b0, pin_oe[1])
      rd(4'h7);
      `CHK("status pin b", ext_val[1], rd_q[1])
    end
    ext_en <= 6'h00;
    v = 3'($random(seed));
    wr(4'h1, {8'h80, v[0], 7'h00});
    @(negedge clock);
    `CHK("pin b drive", {1'b1, v[0]}, {pin_oe[1], pin_out[1]})
    wr(4'h1, 16'h0000);
    $display("test gpio done");
    wr(4'h3, 16'h0001);
    ext_en <= 6'h01;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      ext_val <= 6'($random(seed));
      settle();
      `CHK("int one", ext_val[0], ext_interrupt_one)
    end
    wr(4'h0, 16'h0100);
    ext_en <= 6'h00;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      timer_two_pwm_out <= 1'($random(seed));
      settle();
      `CHK("pin a pwm", timer_two_pwm_out, pin_out[0])
      `CHK("int one loop", timer_two_pwm_out, ext_interrupt_one)
    end
    wr(4'h3, 16'h0000);
    @(negedge clock);
    `CHK("int one off", 1'b1, ext_interrupt_one)
    wr(4'h0, 16'h0000);
    $display("test pin a done");
    ext_en <= 6'h02;
    for (int k = 0; k < 3; k++) begin
      wr(4'h4 + 4'(k), 16'h0001);
      ext_val <= {4'($random(seed)), 2'b00};
      settle();
      `CHK("pin b low", exp_per(k, 1'b0), per)
      @(posedge clock);
      ext_val <= 6'($random(seed));
      settle();
      `CHK("pin b fn", exp_per(k, ext_val[1]), per)
      wr(4'h4 + 4'(k), 16'h0000);
    end
    for (int k = 0; k < 3; k++) wr(4'h4 + 4'(k), 16'h0001);
    ext_en <= 6'h00;
    wr(4'h0, 16'h0080);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      cpu_clock_source <= 1'($random(seed));
      @(negedge clock);
      `CHK("clock out", {1'b1, cpu_clock_source}, {pin_oe[1], pin_out[1]})
      `CHK("inputs held", 3'h7, per)
    end
    $display("test pin b done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 3'h7 : 3'($random(seed));
      @(posedge clock);
      pwm_channel_out <= 3'($random(seed));
      wr(4'h0, {9'h000, v, 4'h0});
      @(negedge clock);
      `CHK("pwm oe", v, pin_oe[4:2])
      `CHK("pwm out", pwm_channel_out & v, pin_out[4:2] & v)
    end
    wr(4'h0, 16'h0000);
    $display("test pwm done");
    wr(4'h2, 16'h2020);
    @(negedge clock);
    `CHK("tdi out", 3'h7, {pin_oe[5], pin_out[5], jtag_tdi})
    @(posedge clock);
    jtag_trst <= 1'b1;
    settle();
    `CHK("tdi oe", 1'b0, pin_oe[5])
    ext_en <= 6'h20;
    ext_val <= 6'h00;
    settle();
    `CHK("tdi in", 1'b0, jtag_tdi)
    $display("test tdi done");
    final_report();
  end
endmodule
